//--- core/lpmc_low_power_mode_controller.sv
// Operating-mode controller: timer-only sleep and STOP mode with warm-up timing.
// Assumes a plain register port on core_clk and an asynchronous stop release pin.
//
// Operation
// R1: Halt bit in low-frequency run enters sleep.
// R2: Sleep halts CPU, gates peripherals except time base.
// R3: Falling edge of selected source resumes clocks.
// R4: Sleep exit restarts CPU in low-frequency run.
// R5: Sleep entry and exit ignore time base enable.
// R6: Interrupt serviced only when three enables set.
// R7: Entered with enable set, latch interrupt on return.
// R8: STOP turns oscillators off, holds state.
// R9: Stop start bit halts core and peripherals.
// R10: Release method: zero edge, one level.
// R11: After warm-up, execution resumes next instruction.
// R12: Return mode picks high or low frequency.
// R13: Port keep bit: zero high-Z, one kept.
// R14: Warm-up select picks one of eight lengths; the code's 2-bit select picks one of four, the return mode picking the set.
// R15: Software sets return mode to match origin.
// R16: Reset release always returns high-frequency run.
// R17: Low two stop-control bits read undefined.
// R18: High-Z entry forces port inputs to zero.
// R19: Software uses level release with key wake-up.
// R20: Stop pin port is high-Z in STOP.
// R21: Sleep release clears halt bit automatically.
// R22: Software never sets idle and halt together.
// R23: STOP entry clears prescaler and divider.
// R24: Warm-up counts oscillator cycles, core clock withheld; the code counts core_clk cycles in their place.
//
// Strobed register access is this design's own decision.
`timescale 1ns/10ps
`default_nettype none
module lpmc_low_power_mode_controller
	import lpmc_pkg::*;
#(
	parameter int unsigned WarmHf00 = lpmc_pkg::WARM_HF_00,
	parameter int unsigned WarmHf01 = lpmc_pkg::WARM_HF_01,
	parameter int unsigned WarmHf10 = lpmc_pkg::WARM_HF_10,
	parameter int unsigned WarmHf11 = lpmc_pkg::WARM_HF_11,
	parameter int unsigned WarmLf00 = lpmc_pkg::WARM_LF_00,
	parameter int unsigned WarmLf01 = lpmc_pkg::WARM_LF_01
) (
	input  wire logic       core_clk,
	input  wire logic       resetn,
	input  wire logic [7:0] regAddr,
	input  wire logic [7:0] regWrData,
	input  wire logic       regWrite,
	input  wire logic       regRead,
	output logic      [7:0] regRdData,
	input  wire logic [7:0] timeBaseSources,
	input  wire logic       stopReleasePin,
	input  wire logic       interruptMasterEnable,
	input  wire logic       timeBaseIrqEnable,
	input  wire logic       timeBaseIrqAck,
	output logic            cpuHalt,
	output logic            periphClkEnable,
	output logic            timeBaseClkEnable,
	output logic            hfOscEnable,
	output logic            lfOscEnable,
	output logic            lowFreqMode,
	output logic            dividerClear,
	output logic            portOutHighZ,
	output logic            portInForceZero,
	output logic            stopPinPortHighZ,
	output logic            timeBaseIrqLatch,
	output logic            timeBaseIrqService
);
	import lpmc_pkg::*;

	lpmc_state_e            state_reg;
	logic [7:0]             stopCtrl_reg;
	logic [3:0]             tbCtrl_reg;
	logic                   lowFreq_reg;
	logic                   tbEnAtEntry_reg;
	logic                   irqLatch_reg;
	logic                   irqService_reg;
	logic                   divClear_reg;
	logic [7:0]             rdData_reg;
	logic [WARM_CNT_W-1:0]  warmCnt_reg;
	logic [7:0]             srcSync1_reg;
	logic [7:0]             srcSync2_reg;
	logic                   srcPrev_reg;
	logic                   pinSync1_reg;
	logic                   pinSync2_reg;
	logic                   pinPrev_reg;
	logic                   wrStop;
	logic                   wrClock;
	logic                   wrTb;
	logic                   srcSel;
	logic                   srcFall;
	logic                   pinRise;
	logic                   sleepEntry;
	logic                   stopEntry;
	logic                   stopRelease;
	logic                   warmDone;
	logic                   sleepExit;

	// Warm-up target in oscillator cycles for a select code and return mode.
	// The two shortest low-frequency lengths are small, so they stay fixed.
	function automatic logic [WARM_CNT_W-1:0] warmTarget(input logic [1:0] sel,
		input logic lowFreq);
		logic [WARM_CNT_W-1:0] t;
		t = '0;
		case ({lowFreq, sel})
			3'b000:  t = WARM_CNT_W'(WarmHf00);
			3'b001:  t = WARM_CNT_W'(WarmHf01);
			3'b010:  t = WARM_CNT_W'(WarmHf10);
			3'b011:  t = WARM_CNT_W'(WarmHf11);
			3'b100:  t = WARM_CNT_W'(WarmLf00);
			3'b101:  t = WARM_CNT_W'(WarmLf01);
			3'b110:  t = WARM_CNT_W'(WARM_LF_10);
			default: t = WARM_CNT_W'(WARM_LF_11);
		endcase
		return t;
	endfunction : warmTarget

	// Address decode for the three registers.
	assign wrStop  = regWrite && (regAddr == STOP_MODE_CTRL_OFF);
	assign wrClock = regWrite && (regAddr == CLOCK_MODE_CTRL_OFF);
	assign wrTb    = regWrite && (regAddr == TIME_BASE_CTRL_OFF);

	// Both external inputs come from outside this clock, so each passes two flops first.
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			srcSync1_reg <= 8'h00;
			srcSync2_reg <= 8'h00;
			pinSync1_reg <= 1'b0;
			pinSync2_reg <= 1'b0;
		end else begin
			srcSync1_reg <= timeBaseSources;
			srcSync2_reg <= srcSync1_reg;
			pinSync1_reg <= stopReleasePin;
			pinSync2_reg <= pinSync1_reg;
		end
	end

	// Edge history taken from the second synchroniser stage only.
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			srcPrev_reg <= 1'b0;
			pinPrev_reg <= 1'b0;
		end else begin
			srcPrev_reg <= srcSel;
			pinPrev_reg <= pinSync2_reg;
		end
	end

	assign srcSel  = srcSync2_reg[tbCtrl_reg[TB_CLK_SEL_LSB +: 3]];
	assign srcFall = srcPrev_reg && !srcSel; // R3
	assign pinRise = pinSync2_reg && !pinPrev_reg;

	// Sleep is only honoured from low-frequency run; enable state plays no part.
	assign sleepEntry = (state_reg == LPMC_RUN) && wrClock && regWrData[CLK_HALT_BIT]
		&& lowFreq_reg; // R1 R5
	assign sleepExit  = (state_reg == LPMC_SLEEP) && srcFall; // R3 R5
	assign stopEntry  = (state_reg == LPMC_RUN) && wrStop && regWrData[STOP_START_BIT]; // R9
	// Level release: pin high; edge release: a rising edge of the pin.
	assign stopRelease = stopCtrl_reg[RELEASE_METH_BIT] ? pinSync2_reg : pinRise; // R10
	assign warmDone = (state_reg == LPMC_WARM) && (warmCnt_reg == warmTarget(
		stopCtrl_reg[WARMUP_SEL_LSB +: 2], stopCtrl_reg[RETURN_MODE_BIT]) - 1'b1); // R14

	// Mode sequencer. A level-mode start with the pin already high skips straight to warm-up.
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			state_reg <= LPMC_RUN; // R16
		end else begin
			case (state_reg)
				LPMC_RUN: begin
					if (stopEntry) begin
						if (regWrData[RELEASE_METH_BIT] && pinSync2_reg) begin
							state_reg <= LPMC_WARM;
						end else begin
							state_reg <= LPMC_STOP; // R8 R9
						end
					end else if (sleepEntry) begin
						state_reg <= LPMC_SLEEP; // R1
					end
				end
				LPMC_SLEEP: begin
					if (sleepExit) begin
						state_reg <= LPMC_RUN; // R4
					end
				end
				LPMC_STOP: begin
					if (stopRelease) begin
						state_reg <= LPMC_WARM; // R10
					end
				end
				LPMC_WARM: begin
					if (warmDone) begin
						state_reg <= LPMC_RUN; // R11
					end
				end
				default: state_reg <= LPMC_RUN;
			endcase
		end
	end

	// Warm-up counter; cycles of core_clk stand for oscillator cycles.
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			warmCnt_reg <= '0;
		end else if (state_reg == LPMC_WARM) begin
			warmCnt_reg <= warmCnt_reg + 1'b1; // R24
		end else begin
			warmCnt_reg <= '0;
		end
	end

	// Stop control register; the start bit falls back to zero when warm-up ends.
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			stopCtrl_reg <= STOP_MODE_CTRL_RESET;
		end else if (warmDone) begin
			stopCtrl_reg[STOP_START_BIT] <= 1'b0; // R11
		end else if (wrStop && state_reg == LPMC_RUN) begin
			stopCtrl_reg <= {regWrData[7:2], 2'b00};
		end
	end

	// Time base control register: enable and source select.
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			tbCtrl_reg <= TIME_BASE_CTRL_RESET[3:0];
		end else if (wrTb) begin
			tbCtrl_reg <= regWrData[3:0];
		end
	end

	// Main clock source. Software picks it in run; STOP return follows the return mode.
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			lowFreq_reg <= 1'b0; // R16
		end else if (warmDone) begin
			lowFreq_reg <= stopCtrl_reg[RETURN_MODE_BIT]; // R12
		end else if (wrClock && state_reg == LPMC_RUN) begin
			lowFreq_reg <= regWrData[LOW_FREQ_SEL_BIT];
		end
	end

	// Record the enable at sleep entry so the latch is set only when it was on.
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			tbEnAtEntry_reg <= 1'b0;
		end else if (sleepEntry) begin
			tbEnAtEntry_reg <= tbCtrl_reg[TB_ENABLE_BIT];
		end
	end

	// Interrupt latch: a set in the same cycle as an acknowledge wins.
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			irqLatch_reg <= 1'b0;
		end else if (sleepExit && tbEnAtEntry_reg) begin
			irqLatch_reg <= 1'b1; // R7
		end else if (timeBaseIrqAck) begin
			irqLatch_reg <= 1'b0;
		end
	end

	// Service request needs all three enables and the CPU running.
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			irqService_reg <= 1'b0;
		end else begin
			irqService_reg <= irqLatch_reg && interruptMasterEnable && timeBaseIrqEnable
				&& tbCtrl_reg[TB_ENABLE_BIT] && (state_reg == LPMC_RUN); // R6
		end
	end

	// One-cycle divider clear at STOP entry.
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			divClear_reg <= 1'b0;
		end else begin
			divClear_reg <= stopEntry; // R23
		end
	end

	// Read port, data valid the cycle after the strobe; unmapped reads give zero.
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			rdData_reg <= 8'h00;
		end else if (regRead) begin
			case (regAddr)
				STOP_MODE_CTRL_OFF:  rdData_reg <= {stopCtrl_reg[7:2], 2'b00}; // R17
				CLOCK_MODE_CTRL_OFF: rdData_reg <= {2'b00, lowFreq_reg, 2'b00,
					state_reg == LPMC_SLEEP, 2'b00}; // R21
				TIME_BASE_CTRL_OFF:  rdData_reg <= {4'h0, tbCtrl_reg};
				default:             rdData_reg <= 8'h00;
			endcase
		end else begin
			rdData_reg <= 8'h00;
		end
	end

	// Outputs derived from the state; the halt bit reads back as sleep state, so it clears on exit.
	assign regRdData          = rdData_reg;
	assign cpuHalt            = (state_reg != LPMC_RUN); // R2 R8 R24
	assign periphClkEnable    = (state_reg == LPMC_RUN); // R2 R3
	assign timeBaseClkEnable  = (state_reg == LPMC_RUN) || (state_reg == LPMC_SLEEP);
	// Oscillators are off in STOP and the return oscillator starts during warm-up.
	assign hfOscEnable = (state_reg == LPMC_WARM) ? !stopCtrl_reg[RETURN_MODE_BIT]
		: (state_reg != LPMC_STOP) && !lowFreq_reg; // R8 R12
	assign lfOscEnable = (state_reg == LPMC_WARM) ? stopCtrl_reg[RETURN_MODE_BIT]
		: (state_reg != LPMC_STOP) && lowFreq_reg; // R8 R12
	assign lowFreqMode        = lowFreq_reg;
	assign dividerClear       = divClear_reg;
	// Port behaviour spans the whole STOP period, warm-up included.
	assign portOutHighZ       = (state_reg == LPMC_STOP || state_reg == LPMC_WARM)
		&& !stopCtrl_reg[PORT_KEEP_BIT]; // R13
	assign portInForceZero    = portOutHighZ; // R18
	assign stopPinPortHighZ   = (state_reg == LPMC_STOP || state_reg == LPMC_WARM); // R20
	assign timeBaseIrqLatch   = irqLatch_reg;
	assign timeBaseIrqService = irqService_reg;

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!resetn);

	sleep_entry_a: assert property (sleepEntry |=> state_reg == LPMC_SLEEP) // R1
		else $error("sleep not entered");
	sleep_gating_a: assert property (state_reg == LPMC_SLEEP |-> cpuHalt && !periphClkEnable
		&& timeBaseClkEnable) // R2
		else $error("sleep gating wrong");
	sleep_wake_a: assert property (state_reg == LPMC_SLEEP && srcFall |=> periphClkEnable) // R3
		else $error("no wake on edge");
	sleep_return_a: assert property (state_reg == LPMC_SLEEP ##1 state_reg == LPMC_RUN
		|-> lowFreqMode && !cpuHalt && rdData_reg[CLK_HALT_BIT] == 1'b0) // R4
		else $error("wrong return mode");
	irq_latch_a: assert property (sleepExit && tbEnAtEntry_reg |=> timeBaseIrqLatch) // R7
		else $error("latch not set");
	irq_gate_a: assert property (timeBaseIrqService |-> $past(interruptMasterEnable)
		&& $past(timeBaseIrqEnable) && $past(tbCtrl_reg[TB_ENABLE_BIT])) // R6
		else $error("service without enables");
	stop_entry_a: assert property (stopEntry && !regWrData[RELEASE_METH_BIT]
		|=> !hfOscEnable && !lfOscEnable && cpuHalt && dividerClear) // R8
		else $error("stop entry wrong");
	level_release_a: assert property (state_reg == LPMC_STOP && stopCtrl_reg[RELEASE_METH_BIT]
		&& pinSync2_reg |=> state_reg == LPMC_WARM) // R10
		else $error("level release missed");
	warm_done_a: assert property (warmDone |=> !cpuHalt
		&& lowFreqMode == $past(stopCtrl_reg[RETURN_MODE_BIT])) // R12
		else $error("warm-up end wrong");
	port_z_a: assert property (state_reg == LPMC_STOP |-> stopPinPortHighZ
		&& portOutHighZ == !stopCtrl_reg[PORT_KEEP_BIT]) // R13
		else $error("port state wrong");
	// STOP-side outputs and the read port, checked cycle by cycle.
	osc_off_a: assert property (state_reg == LPMC_STOP // R8
		|-> !hfOscEnable && !lfOscEnable)
		else $error("oscillator on in stop");
	div_pulse_a: assert property (dividerClear // R23
		|-> $past(stopEntry))
		else $error("divider clear without stop entry");
	port_in_zero_a: assert property (state_reg == LPMC_STOP && !stopCtrl_reg[PORT_KEEP_BIT] // R18
		|-> portInForceZero)
		else $error("port inputs not forced low");
	stop_pin_z_a: assert property (state_reg == LPMC_WARM // R20
		|-> stopPinPortHighZ && !periphClkEnable)
		else $error("stop pin port driven in warm-up");
	rd_undef_a: assert property (regRead && regAddr == STOP_MODE_CTRL_OFF // R17
		|=> regRdData[1:0] == 2'b00)
		else $error("low control bits not masked");
	warm_hold_a: assert property (state_reg == LPMC_WARM && !warmDone // R24
		|=> state_reg == LPMC_WARM && cpuHalt)
		else $error("warm-up cut short");
	halt_clear_a: assert property (state_reg == LPMC_RUN && regRead // R21
		&& regAddr == CLOCK_MODE_CTRL_OFF |=> regRdData[CLK_HALT_BIT] == 1'b0)
		else $error("halt bit still set in run");

	sleep_cycle_c: cover property (sleepEntry ##[1:50] sleepExit);
	stop_cycle_c: cover property (stopEntry ##[1:50] warmDone);
	level_skip_c: cover property (stopEntry && regWrData[RELEASE_METH_BIT] && pinSync2_reg);
	irq_service_c: cover property (timeBaseIrqService);
	stop_edge_c: cover property (state_reg == LPMC_STOP && !stopCtrl_reg[RELEASE_METH_BIT]
		&& stopRelease);
endmodule : lpmc_low_power_mode_controller
`default_nettype wire

//--- core/lpmc_pkg.sv
// Shared constants for the low-power mode controller: register map, fields, warm-up figures.
// Assumes a byte-wide register port and one core clock at 20 MHz.
package lpmc_pkg;
	localparam int unsigned CORE_CLK_HZ = 20_000_000;

	// Register offsets.
	localparam logic [7:0] TIME_BASE_CTRL_OFF   = 8'h36;
	localparam logic [7:0] STOP_MODE_CTRL_OFF   = 8'h38;
	localparam logic [7:0] CLOCK_MODE_CTRL_OFF  = 8'h39;
	localparam logic [7:0] STOP_MODE_CTRL_RESET = 8'h00;
	localparam logic [7:0] TIME_BASE_CTRL_RESET = 8'h00;

	// Field positions in stop_mode_control.
	localparam int STOP_START_BIT = 7;
	localparam int RELEASE_METH_BIT = 6;
	localparam int RETURN_MODE_BIT = 5;
	localparam int PORT_KEEP_BIT = 4;
	localparam int WARMUP_SEL_LSB = 2;
	// Field positions in clock_mode_control.
	localparam int LOW_FREQ_SEL_BIT = 5;
	localparam int CLK_HALT_BIT = 2;
	// Field positions in time_base_control.
	localparam int TB_ENABLE_BIT = 3;
	localparam int TB_CLK_SEL_LSB = 0;

	// Warm-up lengths in oscillator cycles, high- and low-frequency sets.
	localparam int unsigned WARM_HF_00 = 3 * (2 ** 16);
	localparam int unsigned WARM_HF_01 = 2 ** 16;
	localparam int unsigned WARM_HF_10 = 3 * (2 ** 14);
	localparam int unsigned WARM_HF_11 = 2 ** 14;
	localparam int unsigned WARM_LF_00 = 3 * (2 ** 13);
	localparam int unsigned WARM_LF_01 = 2 ** 13;
	localparam int unsigned WARM_LF_10 = 3 * (2 ** 6);
	localparam int unsigned WARM_LF_11 = 2 ** 6;
	localparam int WARM_CNT_W = 18;

	typedef enum logic [3:0] {
		LPMC_RUN   = 4'b0001,
		LPMC_SLEEP = 4'b0010,
		LPMC_STOP  = 4'b0100,
		LPMC_WARM  = 4'b1000
	} lpmc_state_e;
endpackage : lpmc_pkg

//--- tb/low_power_mode_controller_bench.sv
// Self-checking bench for the low-power mode controller: register, STOP and sleep tests.
// Assumes the design package and the wake source model are compiled first.
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) begin checksDone++; if ((got) !== (exp)) begin nErrors++; \
	$display("mismatch at %0t: got %h expected %h", $time, got, exp); end end
module low_power_mode_controller_bench;
	import lpmc_pkg::*;
	localparam int unsigned WARM_HF [4] = '{20, 16, 12, 10};
	logic       core_clk;
	logic       resetn;
	logic [7:0] regAddr;
	logic [7:0] regWrData;
	logic       regWrite;
	logic       regRead;
	logic [7:0] regRdData;
	logic [7:0] timeBaseSources;
	logic       stopReleasePin;
	logic       interruptMasterEnable;
	logic       timeBaseIrqEnable;
	logic       timeBaseIrqAck;
	logic       cpuHalt;
	logic       periphClkEnable;
	logic       timeBaseClkEnable;
	logic       hfOscEnable;
	logic       lfOscEnable;
	logic       lowFreqMode;
	logic       dividerClear;
	logic       portOutHighZ;
	logic       portInForceZero;
	logic       stopPinPortHighZ;
	logic       timeBaseIrqLatch;
	logic       timeBaseIrqService;
	logic [7:0] d;
	int         n;
	int         nErrors = 0;
	int         checksDone = 0;
	int         cycleCount = 0;

	// Short high-frequency warm-up counts keep the run brief; expectations use the same figures.
	lpmc_low_power_mode_controller #(.WarmHf00(20), .WarmHf01(16), .WarmHf10(12),
		.WarmHf11(10)) dut (
		.core_clk(core_clk), .resetn(resetn), .regAddr(regAddr), .regWrData(regWrData),
		.regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
		.timeBaseSources(timeBaseSources), .stopReleasePin(stopReleasePin),
		.interruptMasterEnable(interruptMasterEnable), .timeBaseIrqEnable(timeBaseIrqEnable),
		.timeBaseIrqAck(timeBaseIrqAck), .cpuHalt(cpuHalt), .periphClkEnable(periphClkEnable),
		.timeBaseClkEnable(timeBaseClkEnable), .hfOscEnable(hfOscEnable),
		.lfOscEnable(lfOscEnable), .lowFreqMode(lowFreqMode), .dividerClear(dividerClear),
		.portOutHighZ(portOutHighZ), .portInForceZero(portInForceZero),
		.stopPinPortHighZ(stopPinPortHighZ), .timeBaseIrqLatch(timeBaseIrqLatch),
		.timeBaseIrqService(timeBaseIrqService));

	// The wake source owns the release pin and the time base clocks.
	lpmc_wake_source wake (.core_clk(core_clk), .stopReleasePin(stopReleasePin),
		.timeBaseSources(timeBaseSources));

	// Clock at 20 MHz.
	initial begin
		core_clk = 1'b0;
		forever #25 core_clk = ~core_clk;
	end

	// A hang is cut short well beyond the few hundred cycles the tests need.
	always @(posedge core_clk) begin
		cycleCount++;
		if (cycleCount == 20000) begin
			nErrors++;
			results();
		end
	end

	task automatic results();
		$display("checks %0d, mismatches %0d", checksDone, nErrors);
		if (nErrors == 0 && checksDone > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : results

	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge core_clk);
		regAddr <= a;
		regWrData <= v;
		regWrite <= 1'b1;
		@(posedge core_clk);
		regWrite <= 1'b0;
		#1;
	endtask : wr

	// Read data stand only in the cycle after the strobe, so they are taken there.
	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		@(posedge core_clk);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge core_clk);
		regRead <= 1'b0;
		#1 v = regRdData;
	endtask : rd

	// Counts cycles until the core runs again, bounded so a stuck mode cannot hang.
	task automatic waitRun(output int c);
		c = 0;
		while (cpuHalt !== 1'b0 && c < 400) begin
			@(posedge core_clk);
			#1 c++;
		end
	endtask : waitRun

	// Main sequence: reset, registers, STOP in both release styles, sleep, reset release.
	initial begin
		resetn = 1'b0;
		regAddr = 8'h00;
		regWrData = 8'h00;
		regWrite = 1'b0;
		regRead = 1'b0;
		interruptMasterEnable = 1'b0;
		timeBaseIrqEnable = 1'b1;
		timeBaseIrqAck = 1'b0;
		repeat (2) @(posedge core_clk);
		resetn <= 1'b1;
		rd(STOP_MODE_CTRL_OFF, d);
		`CHK(d, STOP_MODE_CTRL_RESET)
		rd(TIME_BASE_CTRL_OFF, d);
		`CHK(d, TIME_BASE_CTRL_RESET)
		rd(8'h10, d);
		`CHK(d, 8'h00)
		wr(STOP_MODE_CTRL_OFF, 8'h5f);
		rd(STOP_MODE_CTRL_OFF, d);
		`CHK(d, 8'h5c)
		for (int w = 0; w < 4; w++) begin
			wr(STOP_MODE_CTRL_OFF, 8'h80 | 8'(w << WARMUP_SEL_LSB));
			`CHK(cpuHalt, 1'b1)
			`CHK(dividerClear, 1'b1)
			`CHK(hfOscEnable, 1'b0)
			`CHK(portOutHighZ, 1'b1)
			`CHK(portInForceZero, 1'b1)
			`CHK(stopPinPortHighZ, 1'b1)
			repeat (5) @(posedge core_clk);
			#1 `CHK(cpuHalt, 1'b1)
			wake.setPin(1'b1);
			waitRun(n);
			`CHK(n >= WARM_HF[w] && n <= WARM_HF[w] + 6, 1'b1)
			`CHK(lowFreqMode, 1'b0)
			`CHK(hfOscEnable, 1'b1)
			wake.setPin(1'b0);
			rd(STOP_MODE_CTRL_OFF, d);
			`CHK(d, 8'(w << WARMUP_SEL_LSB))
		end
		wr(CLOCK_MODE_CTRL_OFF, 8'h20);
		wake.setPin(1'b1);
		wr(STOP_MODE_CTRL_OFF, 8'hfc);
		`CHK(portOutHighZ, 1'b0)
		`CHK(stopPinPortHighZ, 1'b1)
		`CHK(lfOscEnable, 1'b0)
		waitRun(n);
		`CHK(n >= WARM_LF_11 && n <= WARM_LF_11 + 6, 1'b1)
		`CHK(lowFreqMode, 1'b1)
		wake.setPin(1'b0);
		wr(TIME_BASE_CTRL_OFF, 8'h0b);
		wr(CLOCK_MODE_CTRL_OFF, 8'h24);
		`CHK(cpuHalt, 1'b1)
		`CHK(periphClkEnable, 1'b0)
		`CHK(timeBaseClkEnable, 1'b1)
		`CHK(lfOscEnable, 1'b1)
		waitRun(n);
		`CHK(n <= 40, 1'b1)
		`CHK(periphClkEnable, 1'b1)
		`CHK(lowFreqMode, 1'b1)
		repeat (2) @(posedge core_clk);
		#1 `CHK(timeBaseIrqLatch, 1'b1)
		`CHK(timeBaseIrqService, 1'b0)
		interruptMasterEnable <= 1'b1;
		repeat (3) @(posedge core_clk);
		#1 `CHK(timeBaseIrqService, 1'b1)
		timeBaseIrqEnable <= 1'b0;
		repeat (2) @(posedge core_clk);
		#1 `CHK(timeBaseIrqService, 1'b0)
		timeBaseIrqEnable <= 1'b1;
		rd(CLOCK_MODE_CTRL_OFF, d);
		`CHK(d[CLK_HALT_BIT], 1'b0)
		@(posedge core_clk);
		timeBaseIrqAck <= 1'b1;
		@(posedge core_clk);
		timeBaseIrqAck <= 1'b0;
		repeat (2) @(posedge core_clk);
		#1 `CHK(timeBaseIrqLatch, 1'b0)
		wr(TIME_BASE_CTRL_OFF, 8'h03);
		wr(CLOCK_MODE_CTRL_OFF, 8'h24);
		`CHK(cpuHalt, 1'b1)
		waitRun(n);
		`CHK(n <= 40, 1'b1)
		repeat (2) @(posedge core_clk);
		#1 `CHK(timeBaseIrqLatch, 1'b0)
		wr(STOP_MODE_CTRL_OFF, 8'he0);
		`CHK(cpuHalt, 1'b1)
		@(posedge core_clk);
		resetn <= 1'b0;
		repeat (2) @(posedge core_clk);
		resetn <= 1'b1;
		@(posedge core_clk);
		#1 `CHK(cpuHalt, 1'b0)
		`CHK(lowFreqMode, 1'b0)
		rd(STOP_MODE_CTRL_OFF, d);
		`CHK(d, STOP_MODE_CTRL_RESET)
		results();
	end
endmodule : low_power_mode_controller_bench
`default_nettype wire

//--- tb/lpmc_wake_source.sv
// Far-side model: the external stop release pin and the time base source clocks.
// Assumes it shares core_clk with the controller and is steered by bench task calls.
`timescale 1ns/10ps
`default_nettype none
module lpmc_wake_source (
	input  wire logic       core_clk,
	output logic            stopReleasePin,
	output logic      [7:0] timeBaseSources
);
	logic [8:0] divCount;

	// Free-running divider; source i toggles every 2^(i+1) cycles, so sleep waits vary by source.
	initial divCount = 9'h000;
	always @(posedge core_clk) begin
		divCount <= divCount + 9'h001;
	end

	// Each source is one divider stage, so its falling edges come at a fixed period.
	assign timeBaseSources = divCount[8:1];

	// The pin is always driven by the wake source, low while no release is wanted.
	initial stopReleasePin = 1'b0;

	// Moves the release pin just after a clock edge, as an external driver would.
	task automatic setPin(input logic level);
		@(posedge core_clk);
		stopReleasePin <= level;
	endtask : setPin
endmodule : lpmc_wake_source
`default_nettype wire
